/* File: rtl/ris_pkg.sv */
// Purpose: Constants for the reader request/status control block
// Assumes: Byte-wide register port, 6-bit address
// Notes:   Offsets are the register addresses as printed
package ris_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_COMMAND_CONTROL  = 6'h01;
    localparam logic [5:0] ADDR_PRIMARY_IRQ_EN   = 6'h02;
    localparam logic [5:0] ADDR_SECONDARY_IRQ_EN = 6'h03;
    localparam logic [5:0] ADDR_PRIMARY_IRQ_FLG  = 6'h04;
    localparam logic [5:0] ADDR_SECONDARY_IRQ_FLG = 6'h05;
    localparam logic [5:0] ADDR_ERROR_FLAGS      = 6'h06;
    localparam logic [5:0] ADDR_FIFO_LEVEL       = 6'h0a;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_COMMAND_CONTROL  = 8'h20;
    localparam logic [7:0] RST_PRIMARY_IRQ_EN   = 8'h80;
    localparam logic [7:0] RST_SECONDARY_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_PRIMARY_IRQ_FLG  = 8'h14;
    localparam logic [7:0] RST_SECONDARY_IRQ_FLG = 8'h00;
    localparam logic [7:0] RST_ERROR_FLAGS      = 8'h00;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int         BIT_SET_CONTROL   = 7;
    localparam int         BIT_RCV_OFF       = 5;
    localparam int         BIT_SOFT_SLEEP    = 4;
    localparam int         BIT_PIN_INVERT    = 7;
    localparam int         BIT_PIN_DRIVE     = 7;
    localparam int         BIT_FIFO_FLUSH    = 7;
    localparam int         BIT_ERR_WRITE     = 7;
    localparam int         BIT_ERR_TEMP      = 6;
    localparam int         BIT_ERR_OVFL      = 4;
    localparam int         BIT_ERR_COLL      = 3;
    localparam int         BIT_ERR_CRC       = 2;
    localparam int         BIT_ERR_PARITY    = 1;
    localparam int         BIT_ERR_FRAME     = 0;
    localparam logic [7:0] MASK_COMMAND_RW   = 8'h3f;
    localparam logic [7:0] MASK_SECOND_EN    = 8'h34;
    localparam logic [7:0] MASK_SECOND_EN_RW = 8'hb4;
    localparam logic [6:0] MASK_SECOND_FLAGS = 7'h34;
    localparam logic [7:0] MASK_ERROR        = 8'hdf;

    // ------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_IDLE = 4'h0;
endpackage : ris_pkg

/* File: rtl/ris_reader_irq_status_control.sv */
// Purpose: Command, request-enable, request-flag and error-flag registers
//          with the request pin driver of a contactless reader
// Assumes: Host port is a one-cycle read/write strobe pair; events are
//          one-cycle pulses from the same clock, except test_signal_input
// Notes:   Command execution itself lives outside; this block only records it
//
// How it works
// - Command write launches command; read returns the command actually running
// - Soft sleep bit one enters software power-down, zero means ready
// - Invert bit selects direct or inverted request pin level
// - Reset invert one with open-drain leaves the request pin floating
// - Drive select zero gives open-drain, one gives push-pull
// - First enable bits six to zero gate the seven primary requests
// - Second enable bits five, four, two gate card, edge, checksum requests
// - Hardware events set their request flag automatically
// - Transmit-done flag sets after the last transmitted bit
// - Receive flag sets on valid data when the valid-only option is on
// - Command end sets idle flag; unknown command forces idle and sets it
// - FIFO alert flags set on alert rising; cleared only by host write
// - Fault flag sets whenever any error bit becomes one
// - Countdown flag sets when timer value reaches zero
// - Card-found flag sets when low-power detection finds a card
// - Test input edge flag sets on either edge of the test pin
// - Checksum flag sets when checksum command has processed all bytes
// - FIFO write fault on host writes during authentication or receive window
// - Overheat sets its fault and switches the antenna drivers off
// - Overflow fault sets on write into full FIFO; only flush clears it
// - Collision fault sets on collision at 106k only, clears at receiver start-up
// - Flush bit resets FIFO pointers and overflow fault; reads back zero
// - Parity fault sets on parity error at 106k only, clears at receiver start-up
// - Frame start fault sets on bad start of frame at 106k only, clears at start-up
`timescale 1ns/1ps

module ris_reader_irq_status_control
    import ris_pkg::*;
#(
    parameter int CMD_WIDTH = 4
)
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Host register port
    input  wire logic [5:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Command engine
    output logic                      cmd_start,
    output logic [CMD_WIDTH-1:0]      cmd_code,
    input  wire logic                 cmd_known,
    input  wire logic                 cmd_done,
    output logic                      receiver_analog_off,
    output logic                      soft_sleep,
    output logic                      fifo_flush,
    output logic                      antenna_off,
    // Hardware events
    input  wire logic                 tx_last_bit_sent,
    input  wire logic                 rx_data_valid,
    input  wire logic                 rx_valid_only_option,
    input  wire logic                 fifo_high_status,
    input  wire logic                 fifo_low_status,
    input  wire logic [15:0]          timer_current_value,
    input  wire logic                 timer_running,
    input  wire logic                 card_found,
    input  wire logic                 test_signal_input,
    input  wire logic                 checksum_active,
    input  wire logic                 checksum_all_done,
    input  wire logic                 fifo_host_write,
    input  wire logic                 fifo_int_write,
    input  wire logic                 fifo_full,
    input  wire logic                 authentication_command,
    input  wire logic                 rf_between_tx_rx,
    input  wire logic                 overheat_detect,
    input  wire logic                 bit_collision,
    input  wire logic                 checksum_error,
    input  wire logic                 parity_error,
    input  wire logic                 rate_106k,
    input  wire logic                 frame_start_error,
    input  wire logic                 receiver_startup,
    // Request pin
    output logic                      request_pending,
    output logic                      request_pin_o,
    output logic                      request_pin_oe
);
    import ris_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] command_r;
    logic [7:0] command_nxt;
    logic [7:0] pri_en_r;
    logic [7:0] sec_en_r;
    logic [6:0] pri_flg_r;
    logic [6:0] pri_flg_nxt;
    logic [6:0] sec_flg_r;
    logic [6:0] sec_flg_nxt;
    logic [7:0] err_r;
    logic [7:0] err_nxt;
    logic       hi_d_r;
    logic       lo_d_r;
    logic       tmr_d_r;
    logic       tin_s1_r;
    logic       tin_s2_r;
    logic       tin_s3_r;
    logic       cmd_busy_r;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire wr_cmd   = reg_wr && (reg_addr == ADDR_COMMAND_CONTROL);
    wire wr_pen   = reg_wr && (reg_addr == ADDR_PRIMARY_IRQ_EN);
    wire wr_sen   = reg_wr && (reg_addr == ADDR_SECONDARY_IRQ_EN);
    wire wr_pflg  = reg_wr && (reg_addr == ADDR_PRIMARY_IRQ_FLG);
    wire wr_sflg  = reg_wr && (reg_addr == ADDR_SECONDARY_IRQ_FLG);
    wire wr_fifol = reg_wr && (reg_addr == ADDR_FIFO_LEVEL);
    wire set_ctl  = reg_wdata[BIT_SET_CONTROL];

    assign fifo_flush = wr_fifol && reg_wdata[BIT_FIFO_FLUSH];

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------
    // Launch on write
    assign cmd_start   = wr_cmd;
    assign cmd_code    = reg_wdata[CMD_WIDTH-1:0];
    // Unknown command falls back to idle
    wire   cmd_unknown = wr_cmd && !cmd_known;
    wire   cmd_end     = (cmd_busy_r && cmd_done) || cmd_unknown;

    always_comb
    begin
        command_nxt = command_r;
        if (wr_cmd)
        begin
            command_nxt = reg_wdata & MASK_COMMAND_RW;
            if (!cmd_known)
            begin
                command_nxt[3:0] = CMD_IDLE;
            end
        end
        else if (cmd_busy_r && cmd_done)
        begin
            command_nxt[3:0] = CMD_IDLE;
        end
    end

    assign soft_sleep          = command_r[BIT_SOFT_SLEEP];
    assign receiver_analog_off = command_r[BIT_RCV_OFF];

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    wire hi_rise  = fifo_high_status && !hi_d_r;
    wire lo_rise  = fifo_low_status && !lo_d_r;
    wire tmr_zero = timer_running && (timer_current_value == 16'h0000);
    wire tmr_hit  = tmr_zero && !tmr_d_r;
    // Either edge of the synchronised test pin
    wire tin_edge = tin_s2_r ^ tin_s3_r;

    // ------------------------------------------------------------
    // Error flags
    // ------------------------------------------------------------
    always_comb
    begin
        err_nxt = err_r;
        if (receiver_startup)
        begin
            err_nxt[BIT_ERR_COLL]   = 1'b0;
            err_nxt[BIT_ERR_PARITY] = 1'b0;
            err_nxt[BIT_ERR_FRAME]  = 1'b0;
            err_nxt[BIT_ERR_CRC]    = 1'b0;
        end
        if (fifo_flush)
        begin
            err_nxt[BIT_ERR_OVFL] = 1'b0;
        end
        if (fifo_host_write && (authentication_command || rf_between_tx_rx))
        begin
            err_nxt[BIT_ERR_WRITE] = 1'b1;
        end
        if (overheat_detect)
        begin
            err_nxt[BIT_ERR_TEMP] = 1'b1;
        end
        if ((fifo_host_write || fifo_int_write) && fifo_full)
        begin
            err_nxt[BIT_ERR_OVFL] = 1'b1;
        end
        if (bit_collision && rate_106k)
        begin
            err_nxt[BIT_ERR_COLL] = 1'b1;
        end
        if (checksum_error)
        begin
            err_nxt[BIT_ERR_CRC] = 1'b1;
        end
        if (parity_error && rate_106k)
        begin
            err_nxt[BIT_ERR_PARITY] = 1'b1;
        end
        if (frame_start_error && rate_106k)
        begin
            err_nxt[BIT_ERR_FRAME] = 1'b1;
        end
        err_nxt = err_nxt & MASK_ERROR;
    end

    assign antenna_off = err_r[BIT_ERR_TEMP];
    wire err_rise = |(err_nxt & ~err_r);

    // ------------------------------------------------------------
    // Request flags: host write first, hardware set wins
    // ------------------------------------------------------------
    logic [6:0] pri_hw;
    logic [6:0] sec_hw;

    always_comb
    begin
        pri_hw[6] = tx_last_bit_sent;
        pri_hw[5] = rx_data_valid && rx_valid_only_option;
        pri_hw[4] = cmd_end;
        pri_hw[3] = hi_rise;
        pri_hw[2] = lo_rise;
        pri_hw[1] = err_rise;
        pri_hw[0] = tmr_hit;
        sec_hw    = 7'h00;
        sec_hw[5] = card_found;
        sec_hw[4] = tin_edge;
        sec_hw[2] = checksum_active && checksum_all_done;
    end

    always_comb
    begin
        pri_flg_nxt = pri_flg_r;
        sec_flg_nxt = sec_flg_r;
        if (wr_pflg)
        begin
            if (set_ctl)
            begin
                pri_flg_nxt = pri_flg_r | reg_wdata[6:0];
            end
            else
            begin
                pri_flg_nxt = pri_flg_r & ~reg_wdata[6:0];
            end
        end
        if (wr_sflg)
        begin
            if (set_ctl)
            begin
                sec_flg_nxt = sec_flg_r | (reg_wdata[6:0] & MASK_SECOND_FLAGS);
            end
            else
            begin
                sec_flg_nxt = sec_flg_r & ~reg_wdata[6:0];
            end
        end
        pri_flg_nxt = pri_flg_nxt | pri_hw;
        sec_flg_nxt = (sec_flg_nxt | sec_hw) & MASK_SECOND_FLAGS;
    end

    // ------------------------------------------------------------
    // State update
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            command_r  <= RST_COMMAND_CONTROL;
            pri_en_r   <= RST_PRIMARY_IRQ_EN;
            sec_en_r   <= RST_SECONDARY_IRQ_EN;
            pri_flg_r  <= RST_PRIMARY_IRQ_FLG[6:0];
            sec_flg_r  <= RST_SECONDARY_IRQ_FLG[6:0];
            err_r      <= RST_ERROR_FLAGS;
            cmd_busy_r <= 1'b0;
        end
        else
        begin
            command_r  <= command_nxt;
            pri_flg_r  <= pri_flg_nxt;
            sec_flg_r  <= sec_flg_nxt;
            err_r      <= err_nxt;
            cmd_busy_r <= (command_nxt[3:0] != CMD_IDLE);
            if (wr_pen)
            begin
                pri_en_r <= reg_wdata;
            end
            if (wr_sen)
            begin
                sec_en_r <= reg_wdata & MASK_SECOND_EN_RW;
            end
        end
    end

    // Edge history and test pin synchroniser
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            hi_d_r   <= 1'b0;
            lo_d_r   <= 1'b0;
            tmr_d_r  <= 1'b0;
            tin_s1_r <= 1'b0;
            tin_s2_r <= 1'b0;
            tin_s3_r <= 1'b0;
        end
        else
        begin
            hi_d_r   <= fifo_high_status;
            lo_d_r   <= fifo_low_status;
            tmr_d_r  <= tmr_zero;
            tin_s1_r <= test_signal_input;
            tin_s2_r <= tin_s1_r;
            tin_s3_r <= tin_s2_r;
        end
    end

    // ------------------------------------------------------------
    // Request pin
    // ------------------------------------------------------------
    // Enabled flags combined
    assign request_pending = |(pri_flg_r & pri_en_r[6:0]) | |(sec_flg_r & sec_en_r[6:0]);
    wire pin_level = request_pending ^ pri_en_r[BIT_PIN_INVERT];
    assign request_pin_o  = sec_en_r[BIT_PIN_DRIVE] ? pin_level : 1'b0;
    assign request_pin_oe = sec_en_r[BIT_PIN_DRIVE] | ~pin_level;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Reserved and set-control read zero
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                ADDR_COMMAND_CONTROL:   reg_rdata <= command_r;
                ADDR_PRIMARY_IRQ_EN:    reg_rdata <= pri_en_r;
                ADDR_SECONDARY_IRQ_EN:  reg_rdata <= sec_en_r;
                ADDR_PRIMARY_IRQ_FLG:   reg_rdata <= {1'b0, pri_flg_r};
                ADDR_SECONDARY_IRQ_FLG: reg_rdata <= {1'b0, sec_flg_r};
                ADDR_ERROR_FLAGS:       reg_rdata <= err_r;
                default:                reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule : ris_reader_irq_status_control

/* File: dv/ris_irq_chk.sv */
// Purpose: Port assertions for the reader request/status block
// Assumes: Enable registers shadowed from host writes
// Notes:   Bound onto every instance of the block
`timescale 1ns/1ps
module ris_irq_chk
    import ris_pkg::*;
#(
    parameter int CMD_WIDTH = 4
)
(
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic [5:0]           reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 cmd_start,
    input wire logic [CMD_WIDTH-1:0] cmd_code,
    input wire logic                 cmd_known,
    input wire logic                 fifo_flush,
    input wire logic                 soft_sleep,
    input wire logic                 antenna_off,
    input wire logic                 overheat_detect,
    input wire logic                 tx_last_bit_sent,
    input wire logic                 test_signal_input,
    input wire logic                 request_pending,
    input wire logic                 request_pin_o,
    input wire logic                 request_pin_oe
);
    logic [7:0] pri_en_r;
    logic [7:0] sec_en_r;
    logic       pin_lvl;
    logic       cmd_wr;
    // ----------------
    // Shadow state
    // ----------------
    // Decoded command write and expected pin level
    assign cmd_wr  = reg_wr && reg_addr == ADDR_COMMAND_CONTROL;
    assign pin_lvl = request_pending ^ pri_en_r[BIT_PIN_INVERT];
    // Follow host writes to the enable registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pri_en_r <= RST_PRIMARY_IRQ_EN;
            sec_en_r <= RST_SECONDARY_IRQ_EN;
        end
        else if (reg_wr && reg_addr == ADDR_PRIMARY_IRQ_EN)
            pri_en_r <= reg_wdata;
        else if (reg_wr && reg_addr == ADDR_SECONDARY_IRQ_EN)
            sec_en_r <= reg_wdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ----------------
    // Assertions
    // ----------------
    chk_cmd_launch: assert property (
        cmd_start == cmd_wr && (!cmd_wr || cmd_code == reg_wdata[CMD_WIDTH-1:0]))
        else $error("command write not launched");
    chk_sleep_bit: assert property (
        cmd_wr |=> soft_sleep == $past(reg_wdata[BIT_SOFT_SLEEP]))
        else $error("sleep bit not taken");
    chk_flush_pulse: assert property (
        fifo_flush == (reg_wr && reg_addr == ADDR_FIFO_LEVEL && reg_wdata[BIT_FIFO_FLUSH]))
        else $error("flush pulse wrong");
    chk_pin_enable: assert property (
        request_pin_oe == (sec_en_r[BIT_PIN_DRIVE] || !pin_lvl))
        else $error("pin enable wrong");
    chk_pin_level: assert property (
        request_pin_oe |-> request_pin_o == pin_lvl)
        else $error("pin level wrong");
    chk_no_source: assert property (
        pri_en_r[6:0] == 7'h00 && (sec_en_r & MASK_SECOND_EN) == 8'h00 |-> !request_pending)
        else $error("request without enabled source");
    chk_tx_request: assert property (
        tx_last_bit_sent && pri_en_r[6] && !reg_wr |=> request_pending)
        else $error("transmit done not requested");
    chk_edge_request: assert property (
        $changed(test_signal_input) && sec_en_r[4] ##1 !reg_wr [*4] |-> request_pending)
        else $error("test input edge not requested");
    chk_overheat_off: assert property (
        overheat_detect |=> antenna_off [*3])
        else $error("antenna not switched off");
    chk_unknown_cmd: assert property (
        cmd_wr && !cmd_known && reg_wdata[3:0] != CMD_IDLE && pri_en_r[4]
            |-> ##[1:2] request_pending)
        else $error("unknown command not flagged");
endmodule : ris_irq_chk

bind ris_reader_irq_status_control ris_irq_chk #(.CMD_WIDTH(CMD_WIDTH)) u_chk (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_known(cmd_known),
    .fifo_flush(fifo_flush), .soft_sleep(soft_sleep), .antenna_off(antenna_off),
    .overheat_detect(overheat_detect), .tx_last_bit_sent(tx_last_bit_sent),
    .test_signal_input(test_signal_input), .request_pending(request_pending),
    .request_pin_o(request_pin_o), .request_pin_oe(request_pin_oe)
);

/* File: dv/ris_host_model.sv */
// Purpose: Host controller side of the register port
// Assumes: One-cycle strobes launched at the falling edge
// Notes:   Released lines carry inverted values
`timescale 1ns/1ps
module ris_host_model
(
    input  wire logic       clk,
    output logic      [5:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // Idle lines at time zero
    initial
    begin
        reg_addr  = 6'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr
    // Read strobe, data taken one cycle on
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask : rd
endmodule : ris_host_model

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the reader request/status block
// Assumes: Host model drives the register port
// Notes:   Events are one-hot pulses on ev
`timescale 1ns/1ps
module testbench;
    import ris_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, cmd_start, rcv_off, sleep, flush, ant_off, pend, pin_o, pin_oe;
    logic [3:0]  cmd_code;
    logic [16:0] ev = '0;
    logic        lvl = 1'b0;
    logic        cmd_known = 1'b1;
    logic [15:0] tval = 16'h0001;
    logic [7:0]  d, cur4, cur5, e2, e3;
    int          mismatches = 0;
    int          check_count = 0;
    localparam logic [7:0] RST_TAB [8] = '{8'h00, RST_COMMAND_CONTROL, RST_PRIMARY_IRQ_EN,
        RST_SECONDARY_IRQ_EN, RST_PRIMARY_IRQ_FLG, RST_SECONDARY_IRQ_FLG, RST_ERROR_FLAGS, 8'h00};
    localparam logic [7:0] EXP_P [15] = '{0: 8'h40, 1: 8'h20, 2: 8'h08, 3: 8'h04, 4: 8'h01,
        5: 8'h00, 6: 8'h00, 14: 8'h00, default: 8'h02};
    localparam logic [7:0] EXP_S [15] = '{5: 8'h20, 6: 8'h04, 14: 8'h10, default: 8'h00};
    localparam logic [7:0] EXP_E [15] = '{7: 8'h08, 8: 8'h02, 9: 8'h01, 10: 8'h04, 11: 8'h10,
        12: 8'h90, 13: 8'hc0, 14: 8'hc0, default: 8'h00};

    always #10 clk = ~clk;

    ris_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    ris_reader_irq_status_control #(.CMD_WIDTH(4)) DUT (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_start(cmd_start), .cmd_code(cmd_code),
        .cmd_known(cmd_known), .cmd_done(ev[16]), .receiver_analog_off(rcv_off),
        .soft_sleep(sleep), .fifo_flush(flush), .antenna_off(ant_off),
        .tx_last_bit_sent(ev[0]), .rx_data_valid(ev[1]), .rx_valid_only_option(lvl),
        .fifo_high_status(ev[2]), .fifo_low_status(ev[3]),
        .timer_current_value(ev[4] ? 16'h0000 : tval), .timer_running(ev[4]),
        .card_found(ev[5]), .test_signal_input(ev[14]), .checksum_active(lvl),
        .checksum_all_done(ev[6]), .fifo_host_write(ev[12]), .fifo_int_write(ev[11]),
        .fifo_full(lvl), .authentication_command(lvl), .rf_between_tx_rx(~lvl),
        .overheat_detect(ev[13]), .bit_collision(ev[7]), .checksum_error(ev[10]),
        .parity_error(ev[8]), .rate_106k(lvl), .frame_start_error(ev[9]),
        .receiver_startup(ev[15]), .request_pending(pend), .request_pin_o(pin_o),
        .request_pin_oe(pin_oe)
    );

    // ----------------
    // Helpers
    // ----------------
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic chk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] g;
        host.rd(a, g);
        cmp(g, e);
    endtask : chk
    task automatic fire(input int k);
        @(negedge clk);
        ev[k] = 1'b1;
        @(negedge clk);
        ev[k] = 1'b0;
    endtask : fire
    // Flag register after a set or clear write
    function automatic logic [7:0] upd(input logic [7:0] c, w, m);
        return w[7] ? (c | (w & m)) : (c & ~(w & m));
    endfunction : upd
    // Expected {pending, enable, driven level}
    function automatic logic [7:0] pins(input logic [7:0] p, s, a, b);
        logic pe;
        logic lv;
        pe = |(p & a & 8'h7f) | |(s & b & MASK_SECOND_EN);
        lv = pe ^ a[7];
        return {5'h0, pe, b[7] | ~lv, (b[7] | ~lv) & lv};
    endfunction : pins

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end

    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        void'($urandom(36181));
        tval = 16'h0001 | 16'($urandom);
        repeat (20) @(negedge clk);
        reset = 1'b0;
        for (int a = 0; a < 8; a++)
            chk(6'(a), RST_TAB[a]);
        cmp({7'h0, pin_oe}, 8'h00);
        // Command, read-only and unmapped places
        for (int i = 0; i < 6; i++)
        begin
            d = 8'($urandom);
            host.wr(ADDR_COMMAND_CONTROL, d);
            chk(ADDR_COMMAND_CONTROL, d & MASK_COMMAND_RW);
            cmp({6'h0, rcv_off, sleep}, {6'h0, d[5:4]});
            fire(16);
            host.wr(ADDR_ERROR_FLAGS, d);
            chk(ADDR_ERROR_FLAGS, 8'h00);
            host.wr(6'h07, d);
            chk(6'h07, 8'h00);
        end
        // Set, clear, enables, request pin
        cur4 = RST_PRIMARY_IRQ_FLG;
        cur5 = 8'h00;
        for (int i = 0; i < 24; i++)
        begin
            d = 8'($urandom);
            cur4 = upd(cur4, d, 8'h7f);
            host.wr(ADDR_PRIMARY_IRQ_FLG, d);
            chk(ADDR_PRIMARY_IRQ_FLG, cur4);
            d = 8'($urandom);
            cur5 = upd(cur5, d, MASK_SECOND_EN);
            host.wr(ADDR_SECONDARY_IRQ_FLG, d);
            chk(ADDR_SECONDARY_IRQ_FLG, cur5);
            e2 = 8'($urandom);
            e3 = 8'($urandom);
            host.wr(ADDR_PRIMARY_IRQ_EN, e2);
            host.wr(ADDR_SECONDARY_IRQ_EN, e3);
            chk(ADDR_PRIMARY_IRQ_EN, e2);
            chk(ADDR_SECONDARY_IRQ_EN, e3 & 8'hb4);
            cmp({5'h0, pend, pin_oe, pin_oe & pin_o}, pins(cur4, cur5, e2, e3));
        end
        // Known, unknown and idle commands
        host.wr(ADDR_PRIMARY_IRQ_EN, 8'h7f);
        host.wr(ADDR_SECONDARY_IRQ_EN, 8'hb4);
        host.wr(ADDR_PRIMARY_IRQ_FLG, 8'h7f);
        host.wr(ADDR_SECONDARY_IRQ_FLG, 8'h7f);
        host.wr(ADDR_COMMAND_CONTROL, 8'h0c);
        chk(ADDR_COMMAND_CONTROL, 8'h0c);
        fire(16);
        chk(ADDR_COMMAND_CONTROL, 8'h00);
        chk(ADDR_PRIMARY_IRQ_FLG, 8'h10);
        host.wr(ADDR_PRIMARY_IRQ_FLG, 8'h7f);
        cmd_known = 1'b0;
        host.wr(ADDR_COMMAND_CONTROL, 8'h07);
        cmd_known = 1'b1;
        chk(ADDR_COMMAND_CONTROL, 8'h00);
        chk(ADDR_PRIMARY_IRQ_FLG, 8'h10);
        host.wr(ADDR_PRIMARY_IRQ_FLG, 8'h7f);
        host.wr(ADDR_COMMAND_CONTROL, 8'h00);
        chk(ADDR_PRIMARY_IRQ_FLG, 8'h00);
        // Hardware events one at a time
        lvl = 1'b1;
        for (int k = 0; k < 15; k++)
        begin
            fire(k);
            repeat (5) @(negedge clk);
            cmp({7'h0, pend}, {7'h0, |(EXP_P[k] | EXP_S[k])});
            chk(ADDR_PRIMARY_IRQ_FLG, EXP_P[k]);
            chk(ADDR_SECONDARY_IRQ_FLG, EXP_S[k]);
            chk(ADDR_ERROR_FLAGS, EXP_E[k]);
            host.wr(ADDR_PRIMARY_IRQ_FLG, 8'h7f);
            host.wr(ADDR_SECONDARY_IRQ_FLG, 8'h7f);
            fire(15);
            host.wr(ADDR_FIFO_LEVEL, 8'h80);
        end
        // Mid-run reset, then write fault from the receive window alone
        lvl = 1'b0;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk(ADDR_ERROR_FLAGS, RST_ERROR_FLAGS);
        fire(12);
        chk(ADDR_ERROR_FLAGS, 8'h80);
        test_done();
    end
endmodule : testbench
